//--- core/mcsync_defines.svh
// Offsets, field positions, reset values and counts of the multichip sync receiver
`ifndef MCSYNC_DEFINES_SVH
`define MCSYNC_DEFINES_SVH

// ==========================================
// Register indices, byte address is index times four
`define CFG2_INDEX       6'h01
`define CAL_INDEX        6'h03
`define UCFG_INDEX       6'h1B
`define STAT_INDEX       6'h20

// ==========================================
// Field positions
`define CFG2_MUX_EN_BIT  8
`define CFG2_OUT_EN_BIT  9
`define CAL_EN_BIT       24
`define UCFG_IN_DLY_LSB  0
`define UCFG_OUT_DLY_LSB 3
`define UCFG_SYNC_EN_BIT 6
`define STAT_SEEN_BIT    2

// ==========================================
// Reset values
`define CFG2_RESET       2'h1
`define UCFG_RESET       7'h00
`define CLKGEN_PRESET    5'h00

// ==========================================
// Counts in system clock cycles, except CAL_SYNC_PULSES which counts sync pulses
`define SYNC_DIV         9'h180
`define SYNC_HIGH        9'h100
`define CLKGEN_LAST      5'h17
`define CAL_FIRST_CYCLES 8'h20
`define CAL_SYNC_PULSES  5'h10

`endif

//--- core/mcsync_pkg.sv
// Types shared by the multichip sync receiver files
package mcsync_pkg;

  typedef enum logic [1:0] {
    cal_idle,
    cal_first,
    cal_sync_wait,
    cal_finish
  } cal_state_type;

  typedef logic [2:0] delay_code_type;

endpackage : mcsync_pkg

//--- core/sync_path_if.sv
// Interface joining the sync core to its edge detector and sync generator
`timescale 1ns/10ps
interface sync_path_if;
  logic sync_pulse;
  logic sync_level;
  logic gen_enable;
  logic gen_out;

  modport detect (output sync_pulse, output sync_level);
  modport generate_side (input gen_enable, output gen_out);
  modport core (input sync_pulse, input sync_level, input gen_out, output gen_enable);
endinterface : sync_path_if

//--- core/sync_edge_detector.sv
// Sync input synchroniser and rising edge detector
`timescale 1ns/10ps
module sync_edge_detector (
  input  wire logic         clk,     // System clock
  input  wire logic         nrst,    // Synchronous reset, active low
  input  wire logic         sync_in, // Sync input pin
  sync_path_if.detect       link     // Pulse and level toward the core
);

  logic meta;
  logic stable;
  logic prev;
  logic pulse;

  // ==========================================
  // Two flops before any logic looks at the pin
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      meta   <= 1'b0;
      stable <= 1'b0;
    end
    else
    begin
      meta   <= sync_in; // R4
      stable <= meta;
    end
  end

  // ==========================================
  // Low then high on two samples gives one pulse
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      prev  <= 1'b0;
      pulse <= 1'b0;
    end
    else
    begin
      prev  <= stable;
      pulse <= stable & ~prev; // R3 R13
    end
  end

  assign link.sync_pulse = pulse;
  assign link.sync_level = stable;

endmodule : sync_edge_detector

//--- core/sync_out_generator.sv
// Free running sync output generator for master mode
`timescale 1ns/10ps
`include "mcsync_defines.svh"
module sync_out_generator (
  input  wire logic         clk,  // System clock
  input  wire logic         nrst, // Synchronous reset, active low
  sync_path_if.generate_side link // Enable in, generated clock out
);

  logic [8:0] div_count;
  logic       out_reg;

  // ==========================================
  // Divider runs regardless of enable so phase never jumps
  always_ff @(posedge clk)
  begin
    if (!nrst)
      div_count <= 9'h000;
    else if (div_count == `SYNC_DIV - 9'h001)
      div_count <= 9'h000; // R12
    else
      div_count <= div_count + 9'h001;
  end

  // High for two thirds of the period
  always_ff @(posedge clk)
  begin
    if (!nrst)
      out_reg <= 1'b0;
    else
      out_reg <= link.gen_enable & (div_count < `SYNC_HIGH); // R12
  end

  assign link.gen_out = out_reg;

endmodule : sync_out_generator

//--- core/multichip_sync_receiver.sv
// Multichip sync receiver with clock generator preset and AXI4-Lite registers
// Behaviour
// [R1] When not master, the device can buffer the sync input out onto the sync output.
// [R2] A 3-bit sync input delay code sits in user configuration bits 2 to 0.
// [R3] Each rising edge of the sync input yields a sync pulse exactly one clock long.
// [R4] The pulse comes from sampling the sync input on the rising system clock edge.
// [R5] The clock generator is a counter on the system clock, loaded with a fixed state by each pulse.
// [R6] The preset state lasts one cycle, then the counter steps on as usual.
// [R7] The board feeds the master's own sync output back to its sync input like the slaves.
// [R8] The board gives every device edge aligned sync inputs and reference clocks.
// [R9] Both delay codes accept every value from 0 to 7.
// [R10] A 3-bit sync output delay code sits in user configuration bits 5 to 3.
// [R11] Sync runs only with user configuration bit 6 set, and calibration waits for it.
// [R12] As master, the sync output is the system clock divided by 384 at a 67% duty cycle.
// [R13] An edge counts only when two consecutive samples show low then high.
`timescale 1ns/10ps
`include "mcsync_defines.svh"
module multichip_sync_receiver (
  input  wire logic        clk,                 // System clock, 100 MHz
  input  wire logic        nrst,                // Synchronous reset, active low
  input  wire logic [7:0]  s_axi_awaddr,        // Write address
  input  wire logic        s_axi_awvalid,       // Write address valid
  output logic             s_axi_awready,       // Write address ready
  input  wire logic [31:0] s_axi_wdata,         // Write data
  input  wire logic [3:0]  s_axi_wstrb,         // Write byte strobes
  input  wire logic        s_axi_wvalid,        // Write data valid
  output logic             s_axi_wready,        // Write data ready
  output logic [1:0]       s_axi_bresp,         // Write response
  output logic             s_axi_bvalid,        // Write response valid
  input  wire logic        s_axi_bready,        // Write response ready
  input  wire logic [7:0]  s_axi_araddr,        // Read address
  input  wire logic        s_axi_arvalid,       // Read address valid
  output logic             s_axi_arready,       // Read address ready
  output logic [31:0]      s_axi_rdata,         // Read data
  output logic [1:0]       s_axi_rresp,         // Read response
  output logic             s_axi_rvalid,        // Read data valid
  input  wire logic        s_axi_rready,        // Read data ready
  input  wire logic        sync_in,             // Sync input pin
  output logic             sync_out,            // Sync output pin
  output logic [2:0]       sync_in_delay_code,  // To the input delay line
  output logic [2:0]       sync_out_delay_code, // To the output delay line
  output logic [4:0]       clkgen_state,        // Internal clock generator state
  output logic             sync_pulse           // Gated sync pulse
);

  sync_path_if link ();

  logic                  aw_full;
  logic [7:0]            aw_addr;
  logic                  w_full;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;
  logic                  do_write;
  logic                  wr_hit;
  logic                  rd_hit;
  logic [31:0]           rd_word;
  logic [1:0]            cfg2;
  logic [6:0]            user_config_register;
  logic                  sync_enable;
  logic                  master_mode;
  logic                  gated_pulse;
  logic                  sync_seen;
  logic [7:0]            pulse_count;
  logic                  cal_done;
  logic                  cal_start;
  logic [7:0]            cal_count;
  logic [4:0]            cal_pulses;
  mcsync_pkg::cal_state_type cal_state;

  // ==========================================
  // Sub-blocks
  sync_edge_detector u_detect (
    .clk     (clk),
    .nrst    (nrst),
    .sync_in (sync_in),
    .link    (link.detect)
  );

  sync_out_generator u_gen (
    .clk  (clk),
    .nrst (nrst),
    .link (link.generate_side)
  );

  assign sync_enable = user_config_register[`UCFG_SYNC_EN_BIT];
  assign master_mode = cfg2[1] & cfg2[0];
  assign link.gen_enable = master_mode;
  assign gated_pulse = link.sync_pulse & sync_enable; // R11

  // ==========================================
  // AXI write channel capture, address and data in either order
  assign s_axi_awready = ~aw_full;
  assign s_axi_wready  = ~w_full;
  assign do_write      = aw_full & w_full & ~s_axi_bvalid;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      aw_full <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && !aw_full)
    begin
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
      aw_full <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && !w_full)
    begin
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
      w_full <= 1'b0;
  end

  always_comb
  begin
    case (aw_addr[7:2])
      `CFG2_INDEX, `CAL_INDEX, `UCFG_INDEX, `STAT_INDEX: wr_hit = 1'b1;
      default:                                           wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================
  // Configuration registers
  always_ff @(posedge clk)
  begin
    if (!nrst)
      cfg2 <= `CFG2_RESET;
    else if (do_write && aw_addr[7:2] == `CFG2_INDEX && w_strb[1])
      cfg2 <= w_data[`CFG2_OUT_EN_BIT:`CFG2_MUX_EN_BIT];
  end

  // All eight codes are legal, no clipping
  always_ff @(posedge clk)
  begin
    if (!nrst)
      user_config_register <= `UCFG_RESET;
    else if (do_write && aw_addr[7:2] == `UCFG_INDEX && w_strb[0])
      user_config_register <= w_data[6:0]; // R2 R9 R10
  end

  assign sync_in_delay_code  = user_config_register[`UCFG_IN_DLY_LSB +: 3];  // R2 R9
  assign sync_out_delay_code = user_config_register[`UCFG_OUT_DLY_LSB +: 3]; // R10 R9

  // Sticky, a new pulse beats a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (!nrst)
      sync_seen <= 1'b0;
    else if (gated_pulse)
      sync_seen <= 1'b1;
    else if (do_write && aw_addr[7:2] == `STAT_INDEX && w_strb[0] && w_data[`STAT_SEEN_BIT])
      sync_seen <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      pulse_count <= 8'h00;
    else if (gated_pulse)
      pulse_count <= pulse_count + 8'h01;
  end

  // ==========================================
  // AXI read channel
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (s_axi_araddr[7:2])
      `CFG2_INDEX: rd_word[`CFG2_OUT_EN_BIT:`CFG2_MUX_EN_BIT] = cfg2;
      `CAL_INDEX:  rd_word[`CAL_EN_BIT] = (cal_state != mcsync_pkg::cal_idle);
      `UCFG_INDEX: rd_word[6:0] = user_config_register;
      `STAT_INDEX: rd_word = {8'h00, pulse_count, 3'h0, clkgen_state, 5'h00, sync_seen,
                              (cal_state != mcsync_pkg::cal_idle), cal_done};
      default:     rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================
  // Calibration sequence, pauses for sync when enabled
  assign cal_start = do_write && aw_addr[7:2] == `CAL_INDEX && w_strb[3] && w_data[`CAL_EN_BIT];

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cal_state  <= mcsync_pkg::cal_idle;
      cal_count  <= 8'h00;
      cal_pulses <= 5'h00;
    end
    else
    begin
      case (cal_state)
        mcsync_pkg::cal_idle:
          if (cal_start)
          begin
            cal_state <= mcsync_pkg::cal_first;
            cal_count <= `CAL_FIRST_CYCLES;
          end
        mcsync_pkg::cal_first:
          if (cal_count != 8'h00)
            cal_count <= cal_count - 8'h01;
          else if (sync_enable)
          begin
            cal_state  <= mcsync_pkg::cal_sync_wait; // R11
            cal_pulses <= 5'h00;
          end
          else
            cal_state <= mcsync_pkg::cal_finish;
        // Without a sync signal this never leaves, as the hardware does
        mcsync_pkg::cal_sync_wait:
          if (cal_pulses == `CAL_SYNC_PULSES)
            cal_state <= mcsync_pkg::cal_finish; // R11
          else if (gated_pulse)
            cal_pulses <= cal_pulses + 5'h01;
        mcsync_pkg::cal_finish:
          cal_state <= mcsync_pkg::cal_idle;
        default:
          cal_state <= mcsync_pkg::cal_idle;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      cal_done <= 1'b0;
    else if (cal_state == mcsync_pkg::cal_finish)
      cal_done <= 1'b1;
    else if (cal_start)
      cal_done <= 1'b0;
  end

  // ==========================================
  // Internal clock generator, preset by the sync pulse
  always_ff @(posedge clk)
  begin
    if (!nrst)
      clkgen_state <= `CLKGEN_PRESET;
    else if (gated_pulse)
      clkgen_state <= `CLKGEN_PRESET; // R5 R6
    else if (clkgen_state == `CLKGEN_LAST)
      clkgen_state <= 5'h00;
    else
      clkgen_state <= clkgen_state + 5'h01; // R6
  end

  assign sync_pulse = gated_pulse; // R3

  // ==========================================
  // Sync output select; slaves pass the input through while cfg2[1] is clear, else drive low
  always_ff @(posedge clk)
  begin
    if (!nrst)
      sync_out <= 1'b0;
    else if (master_mode)
      sync_out <= link.gen_out; // R12
    else if (!cfg2[1])
      sync_out <= link.sync_level; // R1 R7
    else
      sync_out <= 1'b0;
  end

endmodule : multichip_sync_receiver

//--- verification/sync_rx_props.sv
// Assertions on the multichip sync receiver ports
`timescale 1ns/10ps
`include "mcsync_defines.svh"
module sync_rx_props (
  input wire logic       clk,                 // System clock
  input wire logic       nrst,                // Synchronous reset, active low
  input wire logic       sync_in,             // Sync input pin
  input wire logic       sync_out,            // Sync output pin
  input wire logic       sync_pulse,          // Gated sync pulse
  input wire logic [4:0] clkgen_state,        // Clock generator state
  input wire logic       s_axi_bvalid,        // Write response valid
  input wire logic [2:0] sync_in_delay_code,  // Input delay code
  input wire logic [2:0] sync_out_delay_code  // Output delay code
);
  logic [8:0] high_run;

  // ==========================================
  // High time of the sync output
  always_ff @(posedge clk)
    if (!nrst || !sync_out)
      high_run <= 9'h000;
    else
      high_run <= high_run + 9'h001;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ==========================================
  // Properties
  property p_pulse_width;
    sync_pulse |=> !sync_pulse [*2];
  endproperty
  a_pulse_width: assert property (p_pulse_width) else $error("sync pulse not single");

  property p_pulse_cause;
    sync_pulse |-> $past(sync_in, 3) && !$past(sync_in, 4);
  endproperty
  a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without low then high");

  property p_preset;
    sync_pulse |=> clkgen_state == `CLKGEN_PRESET;
  endproperty
  a_preset: assert property (p_preset) else $error("clock generator not preset");

  property p_resume;
    sync_pulse ##1 1'b1 |=> clkgen_state == `CLKGEN_PRESET + 5'h01;
  endproperty
  a_resume: assert property (p_resume) else $error("preset state held too long");

  property p_step;
    // Only edges where the design was out of reset make a step
    nrst && !sync_pulse |=>
      clkgen_state == (($past(clkgen_state) == `CLKGEN_LAST) ? 5'h00 : $past(clkgen_state) + 5'h01);
  endproperty
  a_step: assert property (p_step) else $error("clock generator skipped a state");

  property p_high_max;
    high_run <= 9'h100;
  endproperty
  a_high_max: assert property (p_high_max) else $error("sync output high too long");

  property p_in_code;
    $changed(sync_in_delay_code) |-> $rose(s_axi_bvalid);
  endproperty
  a_in_code: assert property (p_in_code) else $error("input delay code changed unbidden");

  property p_out_code;
    $changed(sync_out_delay_code) |-> $rose(s_axi_bvalid);
  endproperty
  a_out_code: assert property (p_out_code) else $error("output delay code changed unbidden");

  c_pulse: cover property (sync_pulse);
  c_master: cover property ($fell(sync_out) && high_run == 9'h100);
  c_write: cover property ($rose(s_axi_bvalid));
endmodule : sync_rx_props

bind multichip_sync_receiver sync_rx_props u_props (
  .clk                 (clk),
  .nrst                (nrst),
  .sync_in             (sync_in),
  .sync_out            (sync_out),
  .sync_pulse          (sync_pulse),
  .clkgen_state        (clkgen_state),
  .s_axi_bvalid        (s_axi_bvalid),
  .sync_in_delay_code  (sync_in_delay_code),
  .sync_out_delay_code (sync_out_delay_code)
);

//--- verification/sync_source.sv
// Sync distribution model driving the receiver's sync input
`timescale 1ns/10ps
module sync_source #(
  parameter int PERIOD = 40,
  parameter int HIGH   = 20
) (
  input  wire logic clk, // Shared reference clock
  input  wire logic run, // Source active
  output logic      sync // Edge aligned sync clock
);
  int   cnt;
  logic level;

  // Idle line rests low, as with a pull-down
  always_ff @(posedge clk)
    if (!run)
    begin
      cnt   <= 0;
      level <= 1'b0;
    end
    else
    begin
      cnt   <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      level <= cnt < HIGH;
    end

  assign sync = level;
endmodule : sync_source

//--- verification/multichip_sync_receiver_tb.sv
// Self-checking testbench for the multichip sync receiver
`timescale 1ns/10ps
`include "mcsync_defines.svh"
module multichip_sync_receiver_tb;
  logic        clk, nrst, sync_in, sync_out, sync_pulse, run, loopback, src;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  sync_in_delay_code, sync_out_delay_code;
  logic [4:0]  clkgen_state;
  int          errors = 0;
  int          tests_run = 0;
  localparam logic [7:0] cfg2_addr = {`CFG2_INDEX, 2'b00};
  localparam logic [7:0] ucfg_addr = {`UCFG_INDEX, 2'b00};
  localparam logic [7:0] cal_addr  = {`CAL_INDEX, 2'b00};
  localparam logic [7:0] stat_addr = {`STAT_INDEX, 2'b00};

  multichip_sync_receiver dut (
    .clk                 (clk),
    .nrst                (nrst),
    .s_axi_awaddr        (s_axi_awaddr),
    .s_axi_awvalid       (s_axi_awvalid),
    .s_axi_awready       (s_axi_awready),
    .s_axi_wdata         (s_axi_wdata),
    .s_axi_wstrb         (s_axi_wstrb),
    .s_axi_wvalid        (s_axi_wvalid),
    .s_axi_wready        (s_axi_wready),
    .s_axi_bresp         (s_axi_bresp),
    .s_axi_bvalid        (s_axi_bvalid),
    .s_axi_bready        (s_axi_bready),
    .s_axi_araddr        (s_axi_araddr),
    .s_axi_arvalid       (s_axi_arvalid),
    .s_axi_arready       (s_axi_arready),
    .s_axi_rdata         (s_axi_rdata),
    .s_axi_rresp         (s_axi_rresp),
    .s_axi_rvalid        (s_axi_rvalid),
    .s_axi_rready        (s_axi_rready),
    .sync_in             (sync_in),
    .sync_out            (sync_out),
    .sync_in_delay_code  (sync_in_delay_code),
    .sync_out_delay_code (sync_out_delay_code),
    .clkgen_state        (clkgen_state),
    .sync_pulse          (sync_pulse)
  );
  sync_source #(.PERIOD(40), .HIGH(20)) src_model (.clk(clk), .run(run), .sync(src));
  // Master mode feeds its own output back, as the board must
  assign sync_in = loopback ? sync_out : src;

  // ==========================================
  // Shared tasks
  task automatic complete_run;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stall;
    errors++;
    $display("mismatch wait expected done seen timeout");
    complete_run();
  endtask : stall

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    repeat (50)
    begin
      @(posedge clk);
      if (s_axi_bvalid)
      begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        return;
      end
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    stall();
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    repeat (50)
    begin
      @(posedge clk);
      if (s_axi_rvalid)
      begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        return;
      end
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    stall();
  endtask : axi_read

  task automatic measure(input logic lvl, output int n);
    for (n = 0; sync_out === lvl; n++)
    begin
      if (n > 900)
        stall();
      step();
    end
  endtask : measure

  task automatic wait_pulse;
    repeat (500)
    begin
      step();
      if (sync_pulse === 1'b1)
        return;
    end
    stall();
  endtask : wait_pulse

  task automatic count_pulses(input int cycles, output int k);
    k = 0;
    repeat (cycles)
    begin
      step();
      if (sync_pulse === 1'b1)
        k++;
    end
  endtask : count_pulses

  // ==========================================
  // Scenarios
  task automatic reset_values;
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(cfg2_addr, d, r);
    check("cfg2", d, 32'h0000_0100);
    axi_read(ucfg_addr, d, r);
    check("ucfg", d, 32'h0000_0000);
    check("sync_out", sync_out, 32'h0000_0000);
  endtask : reset_values

  task automatic delay_codes;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 8; i++)
    begin
      axi_write(ucfg_addr, {26'h0, 3'(7 - i), 3'(i)}, 4'h1, r);
      check("wresp", r, 2'h0);
      step();
      check("in_code", sync_in_delay_code, i);
      check("out_code", sync_out_delay_code, 7 - i);
    end
    // Unmapped place must refuse both ways
    axi_write(8'h40, 32'h0000_0001, 4'hf, r);
    check("unmapped_bresp", r, 2'h2);
    axi_read(8'h40, d, r);
    check("unmapped_rresp", r, 2'h2);
    check("unmapped_rdata", d, 32'h0000_0000);
  endtask : delay_codes

  task automatic pulse_preset;
    logic [1:0] r;
    int         k;
    axi_write(ucfg_addr, 32'h0000_0040, 4'h1, r);
    @(posedge clk);
    run <= 1'b1;
    wait_pulse();
    step();
    check("pulse_width", sync_pulse, 1'b0);
    check("preset", clkgen_state, `CLKGEN_PRESET);
    step();
    check("resume", clkgen_state, `CLKGEN_PRESET + 5'h01);
    count_pulses(118, k);
    check("pulse_rate", k, 3);
    axi_write(ucfg_addr, 32'h0000_0000, 4'h1, r);
    count_pulses(120, k);
    check("gated", k, 0);
    @(posedge clk);
    run <= 1'b0;
  endtask : pulse_preset

  task automatic master_out;
    logic [1:0] r;
    int         n;
    axi_write(cfg2_addr, 32'h0000_0300, 4'h2, r);
    measure(1'b1, n);
    measure(1'b0, n);
    measure(1'b1, n);
    check("high", n, 256);
    measure(1'b0, n);
    check("low", n, 128);
    axi_write(ucfg_addr, 32'h0000_0040, 4'h1, r);
    @(posedge clk);
    loopback <= 1'b1;
    wait_pulse();
    step();
    check("loop_preset", clkgen_state, `CLKGEN_PRESET);
  endtask : master_out

  task automatic slave_pass;
    logic [1:0] r;
    int         n;
    @(posedge clk);
    loopback <= 1'b0;
    run      <= 1'b1;
    axi_write(cfg2_addr, 32'h0000_0100, 4'h2, r);
    measure(1'b1, n);
    measure(1'b0, n);
    measure(1'b1, n);
    check("pass_high", n, 20);
    measure(1'b0, n);
    check("pass_low", n, 20);
  endtask : slave_pass

  task automatic calibration;
    logic [31:0] d;
    logic [1:0]  r;
    int          k;
    // Without bit 6 nothing is seen and calibration runs straight through
    axi_write(ucfg_addr, 32'h0000_0000, 4'h1, r);
    axi_write(stat_addr, 32'h0000_0004, 4'h1, r);
    axi_read(stat_addr, d, r);
    check("seen_clear", d[2], 1'b0);
    axi_write(cal_addr, 32'h0100_0000, 4'h8, r);
    count_pulses(40, k);
    axi_read(stat_addr, d, r);
    check("cal_plain", d[2:0], 3'h1);
    // With bit 6 set it stays busy until sixteen sync pulses pass
    axi_write(ucfg_addr, 32'h0000_0040, 4'h1, r);
    axi_write(cal_addr, 32'h0100_0000, 4'h8, r);
    count_pulses(40, k);
    axi_read(stat_addr, d, r);
    check("cal_wait", d[2:0], 3'h6);
    count_pulses(700, k);
    axi_read(stat_addr, d, r);
    check("cal_sync", d[2:0], 3'h5);
  endtask : calibration

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    nrst          = 1'b0;
    run           = 1'b0;
    loopback      = 1'b0;
    s_axi_awaddr  = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = 32'h0000_0000;
    s_axi_wstrb   = 4'h0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    reset_values();
    delay_codes();
    pulse_preset();
    master_out();
    slave_pass();
    calibration();
    complete_run();
  end
endmodule : multichip_sync_receiver_tb
